// >>> core/pbsp_pkg.sv
// Constants and state layout for the pipelined burst memory port.
package pbsp_pkg;

   // =========================================================================
   // Widths and depths.
   // =========================================================================
   localparam int ADDR_W     = 17;      // Word address, 128K locations.
   localparam int MEM_DEPTH  = 131072;  // Number of stored words.
   localparam int DATA_W     = 32;      // Data lines.
   localparam int LANES      = 4;       // Byte lanes, one parity bit each.
   localparam int LANE_W     = 8;       // Data bits per lane.
   localparam int WORD_W     = 36;      // Data plus parity per word.
   localparam int PAIR_W     = 2;       // Burst counter width.
   localparam int HI_W       = 15;      // Address bits above the pair.
   localparam int FIFO_DEPTH = 32;      // Write buffer depth.

   // =========================================================================
   // Write buffer entry layout: address, word, lane enables.
   // =========================================================================
   localparam int ENT_BW_LSB   = 0;
   localparam int ENT_WORD_LSB = ENT_BW_LSB + LANES;
   localparam int ENT_ADDR_LSB = ENT_WORD_LSB + WORD_W;
   localparam int ENTRY_W      = ENT_ADDR_LSB + ADDR_W;

   // =========================================================================
   // Encodings and reset values.
   // =========================================================================
   localparam logic              ORDER_LINEAR = 1'b0;  // Strap tied low.
   localparam logic [PAIR_W-1:0] STEP_ZERO    = 2'h0;
   localparam logic [PAIR_W-1:0] STEP_ONE     = 2'h1;

   // All pipeline and burst state of the port in one word; the core and the write buffer sit apart.
   typedef struct packed {
      logic                sleep_meta;   // Sleep request, first stage.
      logic                sleep_sync;   // Sleep request, settled.
      logic                interleave;   // Captured burst order strap.
      logic                burst_act;    // A burst may still advance.
      logic                burst_wr;     // Type held for the whole burst.
      logic [HI_W-1:0]     addr_hi;      // Upper address of the burst.
      logic [PAIR_W-1:0]   start_pair;   // Seed of the burst counter.
      logic [PAIR_W-1:0]   step;         // Beats taken since the load.
      logic                s1_valid;     // Address stage holds an access.
      logic                s1_wr;        // Address stage is a write.
      logic [ADDR_W-1:0]   s1_addr;      // Address stage location.
      logic [LANES-1:0]    s1_bw;        // Address stage lane enables.
      logic                s2_valid;     // Data stage holds an access.
      logic                s2_wr;        // Data stage is a write.
      logic [ADDR_W-1:0]   s2_addr;      // Data stage location.
      logic [LANES-1:0]    s2_bw;        // Data stage lane enables.
      logic [WORD_W-1:0]   rd_word;      // Output register.
   } pbsp_state_t;

   localparam pbsp_state_t PBSP_RST = '0;

endpackage : pbsp_pkg

// >>> core/pbsp_fifo.sv
// Parameterised valid/ready FIFO used as the write buffer.
`timescale 1ns/100ps
`default_nettype none

module pbsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int PTR_W = $clog2(DEPTH);

   // =========================================================================
   // Storage and pointers.
   // =========================================================================
   logic [WIDTH-1:0] store [0:DEPTH-1];  // Entries.
   logic [PTR_W-1:0] wr_ptr_ff;          // Next slot to fill.
   logic [PTR_W-1:0] rd_ptr_ff;          // Oldest entry.
   logic [PTR_W:0]   count_ff;           // Entries held.
   logic             push;               // Entry accepted this edge.
   logic             pop;                // Entry drained this edge.

   // Full and empty come straight from the count, so both are exact.
   assign in_ready  = (count_ff != (PTR_W+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = store[rd_ptr_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointers and count; a push with a pop keeps the count.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= PTR_W'(wr_ptr_ff + 1'b1);
         if (pop)
            rd_ptr_ff <= PTR_W'(rd_ptr_ff + 1'b1);
         if (push && !pop)
            count_ff <= (PTR_W+1)'(count_ff + 1'b1);
         else if (pop && !push)
            count_ff <= (PTR_W+1)'(count_ff - 1'b1);
      end
   end

   // Storage needs no reset; the count guards it.
   always_ff @(posedge sys_clk)
   begin
      if (push)
         store[wr_ptr_ff] <= in_data;
   end

endmodule // pbsp_fifo

`default_nettype wire

// >>> core/pbsp_port.sv
// Pipelined burst memory port: pipeline, burst counter, core, bus drive.
`timescale 1ns/100ps
`default_nettype none

module pbsp_port (
   // Clock and reset.
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   // Clock qualification and sleep.
   input  wire logic                          clock_qualify_n,
   input  wire logic                          sleep_request,
   input  wire logic                          burst_order_strap,
   // Address and access control.
   input  wire logic [pbsp_pkg::ADDR_W-1:0]   address,
   input  wire logic                          chip_select_first_n,
   input  wire logic                          chip_select_second,
   input  wire logic                          chip_select_third_n,
   input  wire logic                          advance_or_load,
   input  wire logic                          write_enable_n,
   input  wire logic [pbsp_pkg::LANES-1:0]    byte_lane_write_n,
   input  wire logic                          output_enable_n,
   // Data lines, split into input, output and enable.
   input  wire logic [pbsp_pkg::DATA_W-1:0]   data_in,
   output logic [pbsp_pkg::DATA_W-1:0]        data_out,
   output logic                               data_oe,
   // Parity lines, one per byte lane.
   input  wire logic [pbsp_pkg::LANES-1:0]    parity_lines_in,
   output logic [pbsp_pkg::LANES-1:0]         parity_lines_out,
   output logic                               parity_lines_oe,
   // Write buffer status.
   output logic                               write_buffer_ready
);

   import pbsp_pkg::*;

   // =========================================================================
   // Helper functions.
   // =========================================================================

   // Burst address pair for a given beat in either order.
   function automatic logic [PAIR_W-1:0] burst_pair(
      input logic [PAIR_W-1:0] seed,
      input logic [PAIR_W-1:0] beat,
      input logic              interleaved
   );
      logic [PAIR_W-1:0] pair;
      pair = PAIR_W'(seed + beat);
      if (interleaved)
         pair = seed ^ beat;
      return pair;
   endfunction

   // Replace the enabled lanes of a word, parity bit with its lane.
   function automatic logic [WORD_W-1:0] lane_merge(
      input logic [WORD_W-1:0] old_word,
      input logic [WORD_W-1:0] new_word,
      input logic [LANES-1:0]  lane_en
   );
      logic [WORD_W-1:0] merged;
      merged = old_word;
      for (int i = 0; i < LANES; i++)
      begin
         if (lane_en[i])
         begin
            merged[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            merged[DATA_W + i]         = new_word[DATA_W + i];
         end
      end
      return merged;
   endfunction

   // =========================================================================
   // Declarations.
   // =========================================================================
   pbsp_state_t       st;            // Registered state.
   pbsp_state_t       nxt_st;        // Next state.
   logic [WORD_W-1:0] core_mem [0:MEM_DEPTH-1];  // Stored words.
   logic              qualified;     // This edge takes effect.
   logic              selected;      // All three selects active.
   logic              capture_wr;    // Write data taken this edge.
   logic [WORD_W-1:0] bus_word;      // Word on the lines, data plus parity.
   logic [ENTRY_W-1:0] push_entry;   // Entry offered to the buffer.
   logic              push_ready;    // Buffer has room.
   logic              head_valid;    // Buffer holds an entry.
   logic [ENTRY_W-1:0] head_entry;   // Oldest buffered entry.
   logic              drain;         // Oldest entry goes to the core now.
   logic [ADDR_W-1:0] head_addr;     // Location of the oldest entry.
   logic [WORD_W-1:0] head_word;     // Word of the oldest entry.
   logic [LANES-1:0]  head_bw;       // Lanes of the oldest entry.
   logic              drive;         // Lines driven by the port.

   // =========================================================================
   // Input qualification.
   // =========================================================================

   // A high qualify input masks the edge; nothing else deselects.
   assign qualified = !clock_qualify_n;
   assign selected  = !chip_select_first_n && chip_select_second
                      && !chip_select_third_n;
   assign bus_word  = {parity_lines_in, data_in};

   // Write data is taken two edges after its address edge.
   assign capture_wr = qualified && st.s2_valid && st.s2_wr
                       && !st.sleep_sync;

   // =========================================================================
   // Write buffer.
   // =========================================================================

   // Writes wait in a buffer until the next qualified edge while awake; one that finds it
   // full is lost, and write_buffer_ready warns of that.
   assign push_entry = {st.s2_addr, bus_word, st.s2_bw};
   assign head_addr  = head_entry[ENT_ADDR_LSB +: ADDR_W];
   assign head_word  = head_entry[ENT_WORD_LSB +: WORD_W];
   assign head_bw    = head_entry[ENT_BW_LSB +: LANES];

   // The core only commits on qualified edges while awake.
   assign drain = head_valid && qualified && !st.sleep_sync;

   pbsp_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (capture_wr),
      .in_ready  (push_ready),
      .in_data   (push_entry),
      .out_valid (head_valid),
      .out_ready (drain),
      .out_data  (head_entry)
   );

   assign write_buffer_ready = push_ready;

   // =========================================================================
   // Next state.
   // =========================================================================

   // Next value of the state word; the core and the write buffer update elsewhere.
   always_comb
   begin
      logic [PAIR_W-1:0] next_step;
      logic [WORD_W-1:0] fetched;
      next_step = PAIR_W'(st.step + STEP_ONE);
      fetched   = core_mem[st.s1_addr];
      nxt_st    = st;

      // Settle the asynchronous sleep request first.
      nxt_st.sleep_meta = sleep_request;
      nxt_st.sleep_sync = st.sleep_meta;

      if (qualified)
      begin
         // Forward writes not yet in the core, oldest first, so a read
         // right behind a write sees the new bytes.
         if (drain && head_addr == st.s1_addr)
            fetched = lane_merge(fetched, head_word, head_bw);
         if (capture_wr && st.s2_addr == st.s1_addr)
            fetched = lane_merge(fetched, bus_word, st.s2_bw);

         // Address stage moves to the data stage.
         nxt_st.s2_valid = st.s1_valid;
         nxt_st.s2_wr    = st.s1_wr;
         nxt_st.s2_addr  = st.s1_addr;
         nxt_st.s2_bw    = st.s1_bw;
         nxt_st.rd_word  = fetched;

         if (st.sleep_sync)
         begin
            // A sleeping port takes no access and drops any burst.
            nxt_st.s1_valid  = 1'b0;
            nxt_st.burst_act = 1'b0;
         end
         else if (!advance_or_load)
         begin
            if (selected)
            begin
               // Load: latch address, type and lanes, seed counter.
               nxt_st.s1_valid   = 1'b1;
               nxt_st.s1_addr    = address;
               nxt_st.s1_wr      = !write_enable_n;
               nxt_st.s1_bw      = ~byte_lane_write_n;
               nxt_st.burst_act  = 1'b1;
               nxt_st.burst_wr   = !write_enable_n;
               nxt_st.addr_hi    = address[ADDR_W-1:PAIR_W];
               nxt_st.start_pair = address[PAIR_W-1:0];
               nxt_st.step       = STEP_ZERO;
            end
            else
            begin
               // Deselect travels down the pipe like any access.
               nxt_st.s1_valid  = 1'b0;
               nxt_st.burst_act = 1'b0;
            end
         end
         else if (st.burst_act)
         begin
            // Advance: selects and strobe ignored.
            nxt_st.step     = next_step;
            nxt_st.s1_valid = 1'b1;
            nxt_st.s1_wr    = st.burst_wr;
            nxt_st.s1_bw    = ~byte_lane_write_n;
            nxt_st.s1_addr  = {st.addr_hi,
                               burst_pair(st.start_pair, next_step,
                                          st.interleave)};
         end
         else
         begin
            // Advancing while deselected stays idle.
            nxt_st.s1_valid = 1'b0;
         end
      end

      // Synchronous reset; the order strap is taken while it is held.
      if (rst)
      begin
         nxt_st            = PBSP_RST;
         nxt_st.interleave = (burst_order_strap != ORDER_LINEAR);
      end
   end

   // =========================================================================
   // State register.
   // =========================================================================

   // Whole state registered each edge; holds are done above.
   always_ff @(posedge sys_clk)
   begin
      st <= nxt_st;
   end

   // =========================================================================
   // Memory core.
   // =========================================================================

   // Only enabled lanes change; all else keeps its contents.
   always_ff @(posedge sys_clk)
   begin
      if (drain)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (head_bw[i])
            begin
               core_mem[head_addr][i*LANE_W +: LANE_W] <=
                  head_word[i*LANE_W +: LANE_W];
               core_mem[head_addr][DATA_W + i] <= head_word[DATA_W + i];
            end
         end
      end
   end

   // =========================================================================
   // Line drive.
   // =========================================================================

   // Drive only in a read data stage with the enable low; writes,
   // deselects and a sleeping port always float.
   assign drive = st.s2_valid && !st.s2_wr && !st.sleep_sync
                  && !output_enable_n;

   assign data_out         = st.rd_word[DATA_W-1:0];
   assign parity_lines_out = st.rd_word[WORD_W-1:DATA_W];
   assign data_oe          = drive;
   assign parity_lines_oe  = drive;

endmodule // pbsp_port

`default_nettype wire

// >>> verification/pbsp_monitor.sv
// Assertion checker on the burst memory port pins.
`timescale 1ns/100ps
`default_nettype none

module pbsp_monitor (
   // Clock and reset.
   input wire logic                         sys_clk,
   input wire logic                         rst,
   // Access control.
   input wire logic                         clock_qualify_n,
   input wire logic                         sleep_request,
   input wire logic                         chip_select_first_n,
   input wire logic                         chip_select_second,
   input wire logic                         chip_select_third_n,
   input wire logic                         advance_or_load,
   input wire logic                         write_enable_n,
   input wire logic                         output_enable_n,
   // Outputs watched.
   input wire logic [pbsp_pkg::DATA_W-1:0]  data_out,
   input wire logic                         data_oe,
   input wire logic                         parity_lines_oe,
   input wire logic                         write_buffer_ready
);
   import pbsp_pkg::*;

   // ====================
   // Shared timing and qualifiers.
   // ====================
   // One clock domain.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic sel;  // All three selects active.
   assign sel = !chip_select_first_n && chip_select_second
                && !chip_select_third_n;

   // Qualified load edge, sleep low for its sync.
   sequence s_go;
      (!sleep_request)[*3] ##0 !clock_qualify_n && !advance_or_load;
   endsequence
   sequence s_rd;
      s_go ##0 sel && write_enable_n;
   endsequence

   // ====================
   // Properties.
   // ====================
   AST_OE_GATE: assert property (
      output_enable_n |-> !data_oe && !parity_lines_oe)
      else $error("driven with enable high");
   AST_PARITY_OE: assert property (data_oe == parity_lines_oe)
      else $error("parity drive differs");
   AST_FREEZE: assert property (clock_qualify_n |=> $stable(data_out))
      else $error("word moved on masked edge");
   AST_READ_DRIVE: assert property (
      s_rd ##1 !clock_qualify_n ##1 !output_enable_n |-> data_oe)
      else $error("read not driven");
   AST_WRITE_FLOAT: assert property (
      s_go ##0 sel && !write_enable_n ##1 !clock_qualify_n |=> !data_oe)
      else $error("driven in write data phase");
   AST_DESEL_FLOAT: assert property (
      s_go ##0 !sel ##1 !clock_qualify_n |=> !data_oe)
      else $error("driven after deselect");
   AST_BACK_TO_BACK: assert property (
      s_rd ##1 s_rd ##1 !clock_qualify_n && !output_enable_n
      ##1 !output_enable_n |-> data_oe)
      else $error("second read not driven");
   AST_SLEEP_QUIET: assert property (
      (sleep_request && !clock_qualify_n)[*5] |-> !data_oe)
      else $error("driven while asleep");
   AST_RESET_STATE: assert property (disable iff (1'h0)
      rst |=> !data_oe && data_out == '0 && write_buffer_ready)
      else $error("outputs not reset");

endmodule // pbsp_monitor

`default_nettype wire

// >>> verification/pbsp_ctl_model.sv
// Memory controller model driving the port's access pins.
`timescale 1ns/100ps
`default_nettype none

module pbsp_ctl_model (
   // Clock in.
   input  wire logic                   sys_clk,
   // Access control out.
   output logic                        clock_qualify_n,
   output logic [pbsp_pkg::ADDR_W-1:0] address,
   output logic                        chip_select_first_n,
   output logic                        chip_select_second,
   output logic                        chip_select_third_n,
   output logic                        advance_or_load,
   output logic                        write_enable_n,
   output logic [pbsp_pkg::LANES-1:0]  byte_lane_write_n,
   // Write data out.
   output logic [pbsp_pkg::DATA_W-1:0] data_in,
   output logic [pbsp_pkg::LANES-1:0]  parity_lines_in
);
   import pbsp_pkg::*;

   // Top bit marks a write beat; the rest is its word.
   logic [WORD_W:0] cur = '0;
   logic [WORD_W:0] ph1 = '0;
   logic [WORD_W:0] ph2 = '0;
   logic            burst_wr = 1'h0;  // Type of the running burst.

   // Start deselected with lines idle.
   initial
   begin
      clock_qualify_n = 1'h0;
      address = '0;
      {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h5;
      advance_or_load = 1'h0;
      write_enable_n = 1'h1;
      byte_lane_write_n = 4'hF;
      {parity_lines_in, data_in} = '0;
   end

   // Write words age one stage per qualified edge.
   always @(posedge sys_clk)
   begin
      if (!clock_qualify_n)
      begin
         ph1 <= cur;
         ph2 <= ph1;
      end
   end

   // Lines toggle outside data phases.
   always @(negedge sys_clk)
   begin
      if (ph2[WORD_W])
         {parity_lines_in, data_in} = ph2[WORD_W-1:0];
      else
         {parity_lines_in, data_in} = ~{parity_lines_in, data_in};
   end

   // One request: 0 deselect, 1 load, 2 advance, 3 stall.
   task automatic op(input int kind, input logic we_n,
                     input logic [ADDR_W-1:0] a,
                     input logic [LANES-1:0] bw,
                     input logic [WORD_W-1:0] w);
      @(negedge sys_clk);
      clock_qualify_n = (kind == 3);
      advance_or_load = (kind == 2);
      {chip_select_first_n, chip_select_second, chip_select_third_n} =
         (kind == 1) ? 3'h2 : 3'h5;
      write_enable_n = we_n;
      address = a;
      byte_lane_write_n = bw;
      // A deselect ends the burst, so the next access must load.
      if (kind < 2)
         burst_wr = (kind == 1) && !we_n;
      cur = {(kind == 1 && !we_n) || (kind == 2 && burst_wr), w};
   endtask

endmodule // pbsp_ctl_model

`default_nettype wire

// >>> verification/tb_pbsp_port.sv
// Self-checking bench for the pipelined burst memory port.
`timescale 1ns/100ps
`default_nettype none

module tb_pbsp_port;
   import pbsp_pkg::*;

   // ====================
   // Pins, reference memory and counters.
   // ====================
   logic                sys_clk = 1'h0;
   logic                rst = 1'h1;
   logic                sleep_request = 1'h0;  // Held low when awake.
   logic                burst_order_strap = 1'h0;
   logic                output_enable_n = 1'h0;
   wire logic           clock_qualify_n, chip_select_first_n;
   wire logic           chip_select_second, chip_select_third_n;
   wire logic           advance_or_load, write_enable_n;
   wire logic [ADDR_W-1:0] address;
   wire logic [LANES-1:0]  byte_lane_write_n, parity_lines_in;
   wire logic [DATA_W-1:0] data_in;
   logic [DATA_W-1:0]      data_out;
   logic [LANES-1:0]       parity_lines_out;
   logic                   data_oe, parity_lines_oe, write_buffer_ready;
   wire logic [WORD_W-1:0] shown = {parity_lines_out, data_out};
   logic [WORD_W-1:0]      mem_ref [logic [ADDR_W-1:0]];
   int                     err_count = 0;
   int                     check_count = 0;

   pbsp_port i_dut (.sys_clk, .rst, .clock_qualify_n, .sleep_request,
      .burst_order_strap, .address, .chip_select_first_n,
      .chip_select_second, .chip_select_third_n, .advance_or_load,
      .write_enable_n, .byte_lane_write_n, .output_enable_n, .data_in,
      .data_out, .data_oe, .parity_lines_in, .parity_lines_out,
      .parity_lines_oe, .write_buffer_ready);
   pbsp_ctl_model i_ctl (.sys_clk, .clock_qualify_n, .address,
      .chip_select_first_n, .chip_select_second, .chip_select_third_n,
      .advance_or_load, .write_enable_n, .byte_lane_write_n, .data_in,
      .parity_lines_in);

   always #10 sys_clk = ~sys_clk;

   // ====================
   // Helpers.
   // ====================
   task automatic chk(input string what, input logic [WORD_W-1:0] seen,
                      input logic [WORD_W-1:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [WORD_W-1:0] pat(input int k);
      return {k[3:0], 32'hA5C3_0F96 ^ {4{k[7:0]}}};
   endfunction

   // Address of beat k of a burst seeded at a.
   function automatic logic [ADDR_W-1:0] beat(input logic [ADDR_W-1:0] a,
                                              input int k);
      logic [PAIR_W-1:0] p;
      p = burst_order_strap ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      return {a[ADDR_W-1:PAIR_W], p};
   endfunction

   // Merge enabled lanes into the reference.
   task automatic note(input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] bw,
                       input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] m;
      m = mem_ref.exists(a) ? mem_ref[a] : '0;
      for (int i = 0; i < LANES; i++)
         if (!bw[i])
         begin
            m[i*LANE_W +: LANE_W] = w[i*LANE_W +: LANE_W];
            m[DATA_W+i] = w[DATA_W+i];
         end
      mem_ref[a] = m;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
                     input logic [WORD_W-1:0] w);
      i_ctl.op(1, 1'h0, a, bw, w);
      note(a, bw, w);
   endtask

   // Two reads back to back; judge the first one edge later.
   task automatic rd(input logic [ADDR_W-1:0] a);
      repeat (2) i_ctl.op(1, 1'h1, a, 4'hF, '0);
      @(negedge sys_clk);
      chk("read word", shown, mem_ref[a]);
      chk("read drive", {data_oe, parity_lines_oe}, 2'h3);
   endtask

   // ====================
   // Scenarios.
   // ====================
   task automatic t_reset(input logic strap);
      rst = 1'h1;
      burst_order_strap = strap;
      repeat (10) @(negedge sys_clk);
      chk("reset word", shown, '0);
      chk("reset flags", {data_oe, parity_lines_oe, write_buffer_ready}, 3'h1);
      rst = 1'h0;
   endtask

   // Full write, then one lane at a time, each read back.
   task automatic t_lanes;
      wr(17'h00040, 4'h0, pat(1));
      rd(17'h00040);
      for (int i = 0; i < LANES; i++)
      begin
         wr(17'h00040, ~(4'h1 << i), pat(i + 2));
         rd(17'h00040);
      end
   endtask

   // Output floated by enable, then a stretched read keeps its word.
   task automatic t_oe_stall;
      output_enable_n = 1'h1;
      i_ctl.op(1, 1'h1, 17'h00040, 4'hF, '0);
      i_ctl.op(0, 1'h1, '0, 4'hF, '0);
      for (int k = 0; k < 4; k++)
      begin
         i_ctl.op(3, 1'h1, '0, 4'hF, '0);
         if (k == 0)
            chk("floated drive", {data_oe, parity_lines_oe}, 2'h0);
         output_enable_n = 1'h0;
         #1;
         chk("stalled word", shown, mem_ref[17'h00040]);
         chk("stalled drive", {data_oe, parity_lines_oe}, 2'h3);
      end
      i_ctl.op(0, 1'h1, '0, 4'hF, '0);
   endtask

   // Sleep refuses a load and keeps contents.
   task automatic t_sleep;
      wr(17'h00077, 4'h0, pat(20));
      repeat (3) i_ctl.op(0, 1'h1, '0, 4'hF, '0);
      sleep_request = 1'h1;
      repeat (4) i_ctl.op(0, 1'h1, '0, 4'hF, '0);
      i_ctl.op(1, 1'h1, 17'h00077, 4'hF, '0);
      i_ctl.op(0, 1'h1, '0, 4'hF, '0);
      @(negedge sys_clk);
      chk("asleep drive", {data_oe, parity_lines_oe}, 2'h0);
      sleep_request = 1'h0;
      repeat (3) i_ctl.op(0, 1'h1, '0, 4'hF, '0);
      rd(17'h00077);
      chk("buffer room", write_buffer_ready, 1'h1);
   endtask

   // Burst write then read; advances carry selects and strobe to ignore.
   task automatic t_burst(input logic strap);
      logic [ADDR_W-1:0] b;
      b = 17'h00101;
      t_reset(strap);
      for (int k = 0; k < 4; k++)
         wr(beat(b, k), 4'h0, pat(8 + k));
      wr(b, 4'h0, pat(12));
      for (int k = 1; k < 4; k++)
      begin
         i_ctl.op(2, 1'h1, ~b, {3'h0, k == 2}, pat(12 + k));
         note(beat(b, k), {3'h0, k == 2}, pat(12 + k));
      end
      repeat (2) i_ctl.op(0, 1'h1, '0, 4'hF, '0);
      i_ctl.op(1, 1'h1, b, 4'hF, '0);
      for (int k = 1; k < 6; k++)
      begin
         i_ctl.op(k < 4 ? 2 : 0, 1'h0, ~b, 4'h0, '0);
         if (k > 1)
            chk("burst beat", shown, mem_ref[beat(b, k - 2)]);
      end
   endtask

   // ====================
   // Sequence, watchdog and verdict.
   // ====================
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      t_reset(1'h0);
      t_lanes;
      t_oe_stall;
      t_sleep;
      t_burst(1'h0);
      t_burst(1'h1);
      give_verdict;
   end

   // Runs take about 106 cycles.
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      err_count++;
      give_verdict;
   end

endmodule // tb_pbsp_port

bind pbsp_port pbsp_monitor i_mon (.sys_clk, .rst, .clock_qualify_n,
   .sleep_request, .chip_select_first_n, .chip_select_second,
   .chip_select_third_n, .advance_or_load, .write_enable_n,
   .output_enable_n, .data_out, .data_oe, .parity_lines_oe,
   .write_buffer_ready);

`default_nettype wire
